// File: hw/altr_tx_retry_ctrl.sv
// async transmit retry, header patching and receive qualification
`timescale 1ns/1ps
`include "altr_defines.svh"
`default_nettype none
module altr_tx_retry_ctrl #(
  parameter int LIM_W   = 4,
  parameter int GAP_W   = 8,
  parameter int UNIT_NS = `ALTR_GAP_UNIT_NS
) (
  // clock, reset, enable
  input  wire logic             clk_i,
  input  wire logic             reset_n_i,
  input  wire logic             ce_i,
  // register port
  input  wire logic [7:0]       addr_i,
  input  wire logic [31:0]      wdata_i,
  input  wire logic             wr_i,
  input  wire logic             rd_i,
  output logic      [31:0]      rdata_o,
  // transmit fifo and link transmitter
  input  wire logic             txf_valid_i,
  input  wire logic [31:0]      txf_data_i,
  input  wire altr_pkg::altr_ack_s ack_i,
  output logic                  tx_start_o,
  output logic      [31:0]      tx_hdr_o,
  output logic      [15:0]      tx_src_id_o,
  output logic                  txf_rewind_o,
  output logic                  txf_release_o,
  output logic                  txf_clear_o,
  // receiver and receive fifo
  input  wire altr_pkg::altr_rx_s rx_i,
  output logic                  arf_wr_o,
  output logic      [31:0]      arf_data_o,
  output logic                  arf_drop_o,
  // phy pin and interrupt
  input  wire logic             link_ready_i,
  output logic                  irq_o
);
  import altr_pkg::*;

  localparam int UNIT_CYC = UNIT_NS / `ALTR_CLK_NS;
  localparam int GCNT_W = GAP_W + $clog2(UNIT_CYC + 1);

  if (LIM_W < 1 || LIM_W > 8 || GAP_W < 1 || GAP_W > 8 || UNIT_CYC < 1) begin : g_chk
    $error("altr_tx_retry_ctrl: unsupported parameter value");
  end

  // ----------------------------------------
  // registers
  // ----------------------------------------
  logic [`ALTR_CTRL_W-1:0] ctrl_r;
  logic [31:0]             node_r;
  logic [31:0]             pkt_r;
  logic [`ALTR_IRQ_W-1:0]  flags_r;
  logic [`ALTR_IRQ_W-1:0]  mask_r;
  logic                    go_r;
  logic [1:0]              ack_stat_r;
  logic [3:0]              ack_code_r;
  logic                    lr_meta_r;
  logic                    lr_r;
  logic [31:0]             rdata_nxt;

  // ----------------------------------------
  // transmit state
  // ----------------------------------------
  altr_state_e             state_r;
  logic [LIM_W-1:0]        retry_cnt_r;
  logic [GCNT_W-1:0]       gap_cnt_r;
  logic [1:0]              rt_r;
  logic                    ev_txd_r;
  logic                    ev_bad_r;
  logic                    ev_bf_r;
  logic                    ev_rxd_r;

  // ----------------------------------------
  // decode
  // ----------------------------------------
  logic                    wr_ctrl;
  logic                    wr_node;
  logic                    wr_pkt;
  logic                    wr_mask;
  logic                    wr_go;
  logic                    wr_rst;
  logic                    rd_irq;
  logic                    async_ok;
  logic                    busy_ack;
  logic [3:0]              tcode;
  logic [LIM_W-1:0]        retry_lim;
  logic [GAP_W-1:0]        retry_gap;
  logic [`ALTR_IRQ_W-1:0]  ev_vec;

  assign wr_ctrl   = wr_i && (addr_i == `ALTR_OFF_CTRL);
  assign wr_node   = wr_i && (addr_i == `ALTR_OFF_NODE);
  assign wr_pkt    = wr_i && (addr_i == `ALTR_OFF_PKT);
  assign wr_mask   = wr_i && (addr_i == `ALTR_OFF_MASK);
  assign wr_go     = wr_i && (addr_i == `ALTR_OFF_GO);
  assign wr_rst    = wr_i && (addr_i == `ALTR_OFF_RST);
  assign rd_irq    = rd_i && (addr_i == `ALTR_OFF_IRQ);
  assign retry_lim = pkt_r[`ALTR_PKT_LIM_LSB +: LIM_W];
  assign retry_gap = pkt_r[`ALTR_PKT_GAP_LSB +: GAP_W];
  assign tcode     = txf_data_i[`ALTR_HDR_TC_LSB +: 4];

  // transmits leave idle and received packets land only with every enable in place; retries from the gap state do not recheck
  assign async_ok = (&ctrl_r)
    && (node_r[15:6] != `ALTR_NODE_BAD)
    && node_r[`ALTR_NODE_VALID]
    && !pkt_r[`ALTR_PKT_SNOOP]
    && lr_r;

  assign busy_ack = (ack_i.stat == 2'b00)
    && ((ack_i.code == `ALTR_ACK_BUSY_X)
    || (ack_i.code == `ALTR_ACK_BUSY_A)
    || (ack_i.code == `ALTR_ACK_BUSY_B));

  // ----------------------------------------
  // link ready synchroniser
  // ----------------------------------------
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      lr_meta_r <= 1'b0;
      lr_r      <= 1'b0;
    end else if (ce_i) begin
      lr_meta_r <= link_ready_i;
      lr_r      <= lr_meta_r;
    end
  end

  // ----------------------------------------
  // software registers
  // ----------------------------------------
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      ctrl_r <= `ALTR_CTRL_W'(`ALTR_RST_VAL);
      node_r <= `ALTR_RST_VAL;
      pkt_r  <= `ALTR_RST_VAL;
      mask_r <= `ALTR_IRQ_W'(`ALTR_RST_VAL);
    end else if (ce_i) begin
      if (wr_ctrl) begin
        ctrl_r <= wdata_i[`ALTR_CTRL_W-1:0];
      end
      if (wr_node) begin
        node_r <= wdata_i;
      end
      if (wr_pkt) begin
        pkt_r <= wdata_i;
      end
      if (wr_mask) begin
        mask_r <= wdata_i[`ALTR_IRQ_W-1:0];
      end
    end
  end

  // software sets go; hardware drops it on completion or retry exhaustion only
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      go_r <= 1'b0;
    end else if (ce_i) begin
      if (wr_go) begin
        go_r <= wdata_i[0];
      end else if (ev_txd_r || ev_bf_r) begin
        go_r <= 1'b0;
      end
    end
  end

  // reset register bits act as one-cycle pulses
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      txf_clear_o <= 1'b0;
    end else if (ce_i) begin
      txf_clear_o <= wr_rst && wdata_i[`ALTR_RST_TXF];
    end
  end

  // ----------------------------------------
  // transmit sequencer
  // ----------------------------------------
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      state_r       <= ST_IDLE;
      retry_cnt_r   <= '0;
      gap_cnt_r     <= '0;
      rt_r          <= `ALTR_RT_1;
      tx_start_o    <= 1'b0;
      tx_hdr_o      <= '0;
      tx_src_id_o   <= '0;
      txf_rewind_o  <= 1'b0;
      txf_release_o <= 1'b0;
      ev_txd_r      <= 1'b0;
      ev_bad_r      <= 1'b0;
      ev_bf_r       <= 1'b0;
      ack_stat_r    <= 2'b00;
      ack_code_r    <= 4'h0;
    end else if (ce_i) begin
      tx_start_o    <= 1'b0;
      txf_rewind_o  <= 1'b0;
      txf_release_o <= 1'b0;
      ev_txd_r      <= 1'b0;
      ev_bad_r      <= 1'b0;
      ev_bf_r       <= 1'b0;
      if (wr_rst && wdata_i[`ALTR_RST_TX]) begin
        state_r <= ST_IDLE;
      end else begin
        unique case (state_r)
          ST_IDLE: begin
            if (go_r && async_ok && txf_valid_i && !ev_txd_r && !ev_bf_r) begin
              state_r     <= ST_HDR;
              retry_cnt_r <= '0;
              rt_r        <= `ALTR_RT_1;
            end
          end
          ST_HDR: begin
            // first fifo quadlet is the header
            if (((`ALTR_TCODE_OK >> tcode) & 16'h0001) != 16'h0000) begin
              state_r    <= ST_SEND;
              tx_start_o <= 1'b1;
              tx_hdr_o   <= {txf_data_i[31:10], rt_r, txf_data_i[7:0]};
              tx_src_id_o <= {txf_data_i[`ALTR_HDR_LOCAL_BUS_SEL] ? `ALTR_BUS_LOCAL
                             : node_r[15:6], node_r[5:0]};
            end else begin
              // go stays high until the host clears it; busy stays high until the host resets the transmitter
              state_r  <= ST_HALT;
              ev_bad_r <= 1'b1;
            end
          end
          ST_SEND: begin
            if (ack_i.valid) begin
              ack_stat_r <= ack_i.stat;
              ack_code_r <= ack_i.code;
              if (!busy_ack) begin
                state_r       <= ST_IDLE;
                txf_release_o <= 1'b1;
                ev_txd_r      <= 1'b1;
              end else if (retry_cnt_r == retry_lim) begin
                state_r       <= ST_IDLE;
                txf_release_o <= 1'b1;
                ev_bf_r       <= 1'b1;
              end else begin
                // packet stays queued; rewind to its head
                state_r      <= ST_GAP;
                txf_rewind_o <= 1'b1;
                retry_cnt_r  <= retry_cnt_r + 1'b1;
                gap_cnt_r    <= GCNT_W'(retry_gap * UNIT_CYC);
                if (!pkt_r[`ALTR_PKT_PROTO]) begin
                  rt_r <= `ALTR_RT_X;
                end else if (ack_i.code == `ALTR_ACK_BUSY_B) begin
                  rt_r <= `ALTR_RT_B;
                end else begin
                  rt_r <= `ALTR_RT_A;
                end
              end
            end
          end
          ST_GAP: begin
            if (gap_cnt_r == '0) begin
              state_r    <= ST_SEND;
              tx_start_o <= 1'b1;
              tx_hdr_o   <= {tx_hdr_o[31:10], rt_r, tx_hdr_o[7:0]};
            end else begin
              gap_cnt_r <= gap_cnt_r - 1'b1;
            end
          end
          ST_HALT: begin
            state_r <= ST_HALT;
          end
          default: begin
            state_r <= ST_IDLE;
          end
        endcase
      end
    end
  end

  // ----------------------------------------
  // receive qualification and trailer
  // ----------------------------------------
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      arf_wr_o   <= 1'b0;
      arf_drop_o <= 1'b0;
      arf_data_o <= '0;
      ev_rxd_r   <= 1'b0;
    end else if (ce_i) begin
      arf_wr_o   <= 1'b0;
      arf_drop_o <= 1'b0;
      ev_rxd_r   <= 1'b0;
      if (rx_i.done) begin
        if (!async_ok || rx_i.crc_err || rx_i.len_err) begin
          arf_drop_o <= 1'b1;
        end else begin
          // damaged packets never land, so ack is complete or pending
          arf_wr_o   <= 1'b1;
          arf_data_o <= {13'h0000, rx_i.spd, 12'h000,
                         rx_i.pend ? `ALTR_ACK_PENDING : `ALTR_ACK_COMPLETE};
          ev_rxd_r   <= 1'b1;
        end
      end
    end
  end

  // ----------------------------------------
  // interrupt flags
  // ----------------------------------------
  always_comb begin
    ev_vec = '0;
    ev_vec[`ALTR_IRQ_TXD] = ev_txd_r;
    ev_vec[`ALTR_IRQ_RXD] = ev_rxd_r;
    ev_vec[`ALTR_IRQ_BAD] = ev_bad_r;
    ev_vec[`ALTR_IRQ_BF]  = ev_bf_r;
  end

  // a new event in the clearing read survives it
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      flags_r <= '0;
    end else if (ce_i) begin
      flags_r <= (rd_irq ? '0 : flags_r) | ev_vec;
    end
  end

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      irq_o <= 1'b0;
    end else if (ce_i) begin
      irq_o <= |(((rd_irq ? '0 : flags_r) | ev_vec) & mask_r);
    end
  end

  // ----------------------------------------
  // read port
  // ----------------------------------------
  always_comb begin
    rdata_nxt = '0;
    unique case (addr_i)
      `ALTR_OFF_CTRL: rdata_nxt[`ALTR_CTRL_W-1:0] = ctrl_r;
      `ALTR_OFF_NODE: rdata_nxt = node_r;
      `ALTR_OFF_PKT:  rdata_nxt = pkt_r;
      `ALTR_OFF_DIAG: begin
        rdata_nxt[0] = lr_r;
        rdata_nxt[`ALTR_DIAG_STAT_LSB +: 2] = ack_stat_r;
        rdata_nxt[`ALTR_DIAG_ACK_LSB +: 4]  = ack_code_r;
      end
      `ALTR_OFF_IRQ:  rdata_nxt[`ALTR_IRQ_W-1:0] = flags_r;
      `ALTR_OFF_MASK: rdata_nxt[`ALTR_IRQ_W-1:0] = mask_r;
      `ALTR_OFF_GO: begin
        rdata_nxt[0] = go_r;
        rdata_nxt[`ALTR_GO_BUSY] = (state_r != ST_IDLE);
      end
      default: rdata_nxt = '0;
    endcase
  end

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      rdata_o <= '0;
    end else if (ce_i) begin
      rdata_o <= rd_i ? rdata_nxt : '0;
    end
  end
endmodule
`default_nettype wire

// File: hw/altr_defines.svh
// register offsets, field positions, reset values and timing for the async retry block
`ifndef ALTR_DEFINES_SVH
`define ALTR_DEFINES_SVH
// ----------------------------------------
// register offsets (byte addresses)
// ----------------------------------------
`define ALTR_OFF_CTRL 8'h04
`define ALTR_OFF_NODE 8'h08
`define ALTR_OFF_PKT 8'h10
`define ALTR_OFF_DIAG 8'h14
`define ALTR_OFF_RST 8'h18
`define ALTR_OFF_IRQ 8'h70
`define ALTR_OFF_MASK 8'h74
`define ALTR_OFF_GO 8'hA4
// ----------------------------------------
// field positions
// ----------------------------------------
`define ALTR_CTRL_W 5
`define ALTR_NODE_VALID 31
`define ALTR_PKT_SNOOP 0
`define ALTR_PKT_PROTO 1
`define ALTR_PKT_GAP_LSB 8
`define ALTR_PKT_LIM_LSB 16
`define ALTR_DIAG_STAT_LSB 4
`define ALTR_DIAG_ACK_LSB 8
`define ALTR_RST_TXF 0
`define ALTR_RST_TX 1
`define ALTR_GO_BUSY 1
`define ALTR_IRQ_W 4
`define ALTR_IRQ_TXD 0
`define ALTR_IRQ_RXD 1
`define ALTR_IRQ_BAD 2
`define ALTR_IRQ_BF 3
`define ALTR_HDR_LOCAL_BUS_SEL 19
`define ALTR_HDR_RT_LSB 8
`define ALTR_HDR_TC_LSB 4
`define ALTR_TRL_SPD_LSB 16
// ----------------------------------------
// constant values and reset values
// ----------------------------------------
`define ALTR_BUS_LOCAL 10'h3FF
`define ALTR_NODE_BAD 10'h3FF
`define ALTR_TCODE_OK 16'h0EF7
`define ALTR_ACK_COMPLETE 4'h1
`define ALTR_ACK_PENDING 4'h2
`define ALTR_ACK_BUSY_X 4'h4
`define ALTR_ACK_BUSY_A 4'h5
`define ALTR_ACK_BUSY_B 4'h6
`define ALTR_RT_1 2'h0
`define ALTR_RT_X 2'h1
`define ALTR_RT_A 2'h2
`define ALTR_RT_B 2'h3
`define ALTR_RST_VAL 32'h0000_0000
// ----------------------------------------
// timing
// ----------------------------------------
`define ALTR_GAP_UNIT_NS 125000
`define ALTR_CLK_NS 40
`endif

// File: hw/altr_pkg.sv
// types shared by the async retry block
package altr_pkg;
  // one-hot transmit states
  typedef enum logic [4:0] {
    ST_IDLE = 5'b00001,
    ST_HDR  = 5'b00010,
    ST_SEND = 5'b00100,
    ST_GAP  = 5'b01000,
    ST_HALT = 5'b10000
  } altr_state_e;
  // acknowledge report from the transmitter
  typedef struct packed {
    logic       valid;
    logic [1:0] stat;
    logic [3:0] code;
  } altr_ack_s;
  // end-of-packet report from the receiver
  typedef struct packed {
    logic       done;
    logic       crc_err;
    logic       len_err;
    logic       pend;
    logic [2:0] spd;
  } altr_rx_s;
endpackage

// File: test/altr_tx_retry_ctrl_sva.sv
// assertion checker for the async retry block
`timescale 1ns/1ps
`include "altr_defines.svh"
`default_nettype none
module altr_tx_retry_ctrl_sva #(
  parameter int UNIT_NS = `ALTR_GAP_UNIT_NS
) (
  // clock and reset
  input  wire logic                clk_i,
  input  wire logic                reset_n_i,
  // register port
  input  wire logic [7:0]          addr_i,
  input  wire logic [31:0]         wdata_i,
  input  wire logic                wr_i,
  // transmit side
  input  wire logic [31:0]         txf_data_i,
  input  wire altr_pkg::altr_ack_s ack_i,
  input  wire logic                tx_start_o,
  input  wire logic [31:0]         tx_hdr_o,
  input  wire logic [15:0]         tx_src_id_o,
  input  wire logic                txf_rewind_o,
  input  wire logic                txf_release_o,
  // receive side and interrupt
  input  wire altr_pkg::altr_rx_s  rx_i,
  input  wire logic                arf_wr_o,
  input  wire logic [31:0]         arf_data_o,
  input  wire logic                arf_drop_o,
  input  wire logic                irq_o
);
  import altr_pkg::*;
  localparam int          GAP_K = UNIT_NS / `ALTR_CLK_NS;
  localparam logic [15:0] TC_OK = `ALTR_TCODE_OK;
  logic [15:0] node_c;
  logic [7:0]  gap_c;
  logic [3:0]  mask_c;
  logic [15:0] gcnt;
  logic        gap_run;
  logic        busy_ack;
  assign busy_ack = ack_i.code inside {`ALTR_ACK_BUSY_X, `ALTR_ACK_BUSY_A, `ALTR_ACK_BUSY_B};
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!reset_n_i);
  // ----
  // shadow of host writes
  // ----
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      node_c <= 16'h0000;
      gap_c <= 8'h00;
      mask_c <= 4'h0;
    end else if (wr_i) begin
      if (addr_i == `ALTR_OFF_NODE) node_c <= wdata_i[15:0];
      if (addr_i == `ALTR_OFF_PKT) gap_c <= wdata_i[15:8];
      if (addr_i == `ALTR_OFF_MASK) mask_c <= wdata_i[3:0];
    end
  end
  // saturating, so a stuck retry cannot wrap and look short
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      gcnt <= 16'h0000;
      gap_run <= 1'h0;
    end else if (txf_rewind_o) begin
      gcnt <= 16'h0000;
      gap_run <= 1'h1;
    end else begin
      if (gcnt != 16'hFFFF) gcnt <= gcnt + 16'h0001;
      if (tx_start_o) gap_run <= 1'h0;
    end
  end
  // ----
  // properties
  // ----
  a_busy_retry: assert property (
    ack_i.valid && busy_ack |=> txf_rewind_o || txf_release_o)
    else $error("busy ack without rewind or release");
  a_ack_done: assert property (
    ack_i.valid && !busy_ack |=> txf_release_o && !txf_rewind_o)
    else $error("final ack without release");
  a_rewind_start: assert property (txf_rewind_o |-> ##[1:1000] tx_start_o)
    else $error("rewind not followed by resend");
  a_retry_gap: assert property (
    tx_start_o && gap_run |-> int'(gcnt) == gap_c * GAP_K)
    else $error("retry not sent after the programmed gap");
  a_start_hdr: assert property (
    tx_start_o |-> ((tx_hdr_o ^ $past(txf_data_i)) & 32'hFFFF_FCFF) == 32'h0)
    else $error("header differs from head quadlet");
  a_tcode_ok: assert property (tx_start_o |-> TC_OK[tx_hdr_o[7:4]])
    else $error("start with illegal tcode");
  a_src_id: assert property (
    tx_start_o |-> tx_src_id_o == {tx_hdr_o[19] ? 10'h3FF : node_c[15:6], node_c[5:0]})
    else $error("wrong source id");
  a_rx_drop: assert property (
    rx_i.done && (rx_i.crc_err || rx_i.len_err) |=> arf_drop_o && !arf_wr_o)
    else $error("bad packet not dropped");
  a_rx_trailer: assert property (
    arf_wr_o |-> $past(rx_i.done) && arf_data_o[18:16] == $past(rx_i.spd)
      && arf_data_o[3:0] == ($past(rx_i.pend) ? `ALTR_ACK_PENDING : `ALTR_ACK_COMPLETE))
    else $error("bad trailer");
  a_irq_masked: assert property (
    mask_c == 4'h0 && $past(mask_c) == 4'h0 |-> !irq_o)
    else $error("interrupt while all masked");
  c_retry: cover property (txf_rewind_o);
  c_drop: cover property (arf_drop_o);
  c_phase_b: cover property (tx_start_o && tx_hdr_o[9:8] == `ALTR_RT_B);
endmodule
bind altr_tx_retry_ctrl altr_tx_retry_ctrl_sva #(.UNIT_NS(UNIT_NS)) sva_u (
  .clk_i(clk_i), .reset_n_i(reset_n_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i),
  .txf_data_i(txf_data_i), .ack_i(ack_i), .tx_start_o(tx_start_o), .tx_hdr_o(tx_hdr_o),
  .tx_src_id_o(tx_src_id_o), .txf_rewind_o(txf_rewind_o), .txf_release_o(txf_release_o),
  .rx_i(rx_i), .arf_wr_o(arf_wr_o), .arf_data_o(arf_data_o), .arf_drop_o(arf_drop_o),
  .irq_o(irq_o));
`default_nettype wire

// File: test/altr_node_model.sv
// remote node model: acknowledges each transmitted packet
`timescale 1ns/1ps
`include "altr_defines.svh"
`default_nettype none
module altr_node_model #(
  parameter int DLY = 3
) (
  // clock and reset
  input  wire logic          clk_i,
  input  wire logic          reset_n_i,
  // packet on the link
  input  wire logic          tx_start_i,
  input  wire logic [31:0]   tx_hdr_i,
  // behaviour
  input  wire logic          dual_i,
  input  wire logic [3:0]    busy_n_i,
  // acknowledge
  output var altr_pkg::altr_ack_s ack_o
);
  import altr_pkg::*;
  logic [2:0] dly;
  logic [3:0] nb;
  logic [3:0] code_w;
  // busy for the first busy_n_i tries; dual phase alternates the two codes
  assign code_w = (nb >= busy_n_i) ? `ALTR_ACK_COMPLETE :
                  !dual_i ? `ALTR_ACK_BUSY_X :
                  nb[0] ? `ALTR_ACK_BUSY_B : `ALTR_ACK_BUSY_A;
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      dly <= 3'h0;
      nb <= 4'h0;
      ack_o <= '0;
    end else begin
      if (tx_start_i) begin
        dly <= DLY[2:0];
        if (tx_hdr_i[9:8] == `ALTR_RT_1) nb <= 4'h0;
      end else if (dly != 3'h0) begin
        dly <= dly - 3'h1;
      end
      if (dly == 3'h1) begin
        ack_o <= '{1'h1, 2'h0, code_w};
        nb <= nb + 4'h1;
      end else begin
        // fields carry junk between acks, the inverted last code and the last code in turn
        ack_o <= '{1'h0, ~ack_o.stat, ~ack_o.code};
      end
    end
  end
endmodule
`default_nettype wire

// File: test/altr_tx_retry_ctrl_tb.sv
// self-checking bench for the async retry block
`timescale 1ns/1ps
`default_nettype none
module altr_tx_retry_ctrl_tb;
  import altr_pkg::*;
  logic        clk_i = 1'h0;
  logic        reset_n_i = 1'h0;
  logic [7:0]  addr_i = 8'h00;
  logic [31:0] wdata_i = 32'h0;
  logic        wr_i = 1'h0;
  logic        rd_i = 1'h0;
  logic [31:0] txf_data_i = 32'h0;
  logic        link_ready_i = 1'h1;
  altr_rx_s    rx_i = '0;
  altr_ack_s   ack_i;
  logic [31:0] rdata_o, tx_hdr_o, arf_data_o;
  logic [15:0] tx_src_id_o;
  logic        tx_start_o, txf_rewind_o, txf_release_o, txf_clear_o;
  logic        arf_wr_o, arf_drop_o, irq_o;
  logic        dual = 1'h0;
  logic        clr_seen = 1'h0;
  logic [3:0]  busy_n = 4'h0;
  logic [1:0]  last_rt = 2'h0;
  int          n_fail = 0;
  int          checked = 0;
  int          n_st = 0;
  // gap unit shortened to 10 cycles
  altr_tx_retry_ctrl #(.UNIT_NS(400)) dut_u (
    .clk_i(clk_i), .reset_n_i(reset_n_i), .ce_i(1'h1), .addr_i(addr_i),
    .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
    .txf_valid_i(1'h1), .txf_data_i(txf_data_i), .ack_i(ack_i), .tx_start_o(tx_start_o),
    .tx_hdr_o(tx_hdr_o), .tx_src_id_o(tx_src_id_o), .txf_rewind_o(txf_rewind_o),
    .txf_release_o(txf_release_o), .txf_clear_o(txf_clear_o), .rx_i(rx_i),
    .arf_wr_o(arf_wr_o), .arf_data_o(arf_data_o), .arf_drop_o(arf_drop_o),
    .link_ready_i(link_ready_i), .irq_o(irq_o));
  altr_node_model node_u (
    .clk_i(clk_i), .reset_n_i(reset_n_i), .tx_start_i(tx_start_o), .tx_hdr_i(tx_hdr_o),
    .dual_i(dual), .busy_n_i(busy_n), .ack_o(ack_i));
  always #20 clk_i = ~clk_i;
  always @(posedge clk_i) begin
    if (tx_start_o === 1'h1) begin
      n_st++;
      last_rt = tx_hdr_o[9:8];
    end
    if (txf_clear_o === 1'h1) clr_seen = 1'h1;
  end
  // ----
  // helpers
  // ----
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      n_fail++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_i);
    addr_i <= a;
    wdata_i <= d;
    wr_i <= 1'h1;
    @(posedge clk_i);
    wr_i <= 1'h0;
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
    @(posedge clk_i);
    addr_i <= a;
    rd_i <= 1'h1;
    @(posedge clk_i);
    rd_i <= 1'h0;
    @(negedge clk_i);
    chk(rdata_o, exp);
  endtask
  function automatic logic [31:0] hdr(input logic bid, input logic [3:0] tc);
    return 32'h0001_2C00 | {12'h0, bid, 19'h0} | {24'h0, tc, 4'h0};
  endfunction
  task automatic complete_run;
    $display("checks %0d failures %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  // ----
  // scenarios
  // ----
  task automatic run_tx(input logic bid, input logic [3:0] tc, input logic dv,
                        input logic [3:0] lim, input logic [3:0] nb, input int st,
                        input logic [3:0] flg);
    int i;
    int k;
    k = st - 1;
    wr(8'h10, {12'h0, lim, 8'h02, 6'h0, dv, 1'h0});
    busy_n <= nb;
    dual <= dv;
    txf_data_i <= hdr(bid, tc);
    n_st = 0;
    wr(8'hA4, 32'h1);
    for (i = 0; i < 3000 && txf_release_o !== 1'h1; i++) @(negedge clk_i);
    chk(i < 3000, 1'h1);
    repeat (4) @(posedge clk_i);
    chk(n_st, st);
    chk(last_rt, (k == 0) ? 2'h0 : !dv ? 2'h1 : k[0] ? 2'h2 : 2'h3);
    chk(tx_src_id_o, {bid ? 10'h3FF : 10'h001, 6'h02});
    chk(irq_o, 1'h1);
    rdc(8'h70, {28'h0, flg});
    if (flg == 4'h1) rdc(8'h14, 32'h101);
    rdc(8'hA4, 32'h0);
  endtask
  task automatic bad_tcode;
    @(posedge clk_i);
    txf_data_i <= hdr(1'h0, 4'h3);
    n_st = 0;
    wr(8'hA4, 32'h1);
    repeat (10) @(posedge clk_i);
    chk(n_st, 0);
    rdc(8'h70, 32'h4);
    rdc(8'hA4, 32'h3);
    wr(8'hA4, 32'h0);
    wr(8'h18, 32'h3);
    repeat (2) @(posedge clk_i);
    chk(clr_seen, 1'h1);
    rdc(8'hA4, 32'h0);
  endtask
  task automatic no_ready;
    @(posedge clk_i);
    txf_data_i <= hdr(1'h0, 4'h1);
    link_ready_i <= 1'h0;
    n_st = 0;
    repeat (4) @(posedge clk_i);
    wr(8'hA4, 32'h1);
    repeat (10) @(posedge clk_i);
    chk(n_st, 0);
    wr(8'hA4, 32'h0);
    link_ready_i <= 1'h1;
    repeat (4) @(posedge clk_i);
  endtask
  task automatic rx_pkt(input logic [1:0] err, input logic pend, input logic [3:0] flg,
                        input logic irq_exp);
    @(posedge clk_i);
    rx_i <= '{1'h1, err[1], err[0], pend, 3'h5};
    @(posedge clk_i);
    rx_i <= '0;
    @(negedge clk_i);
    chk(arf_wr_o, err == 2'h0);
    chk(arf_drop_o, err != 2'h0);
    if (err == 2'h0)
      chk({arf_data_o[18:16], arf_data_o[3:0]}, {3'h5, pend ? 4'h2 : 4'h1});
    repeat (2) @(negedge clk_i);
    chk(irq_o, irq_exp);
    rdc(8'h70, {28'h0, flg});
  endtask
  // ----
  // main sequence and watchdog
  // ----
  initial begin
    repeat (2) @(posedge clk_i);
    reset_n_i <= 1'h1;
    rdc(8'h04, 32'h0);
    wr(8'h40, 32'hFFFF_FFFF);
    rdc(8'h40, 32'h0);
    wr(8'h04, 32'h1F);
    wr(8'h08, 32'h8000_0042);
    wr(8'h74, 32'hF);
    run_tx(1'h1, 4'h1, 1'h1, 4'h2, 4'hF, 3, 4'h8);
    run_tx(1'h0, 4'h1, 1'h1, 4'h2, 4'h2, 3, 4'h1);
    run_tx(1'h0, 4'h4, 1'h0, 4'h3, 4'h1, 2, 4'h1);
    bad_tcode();
    no_ready();
    rx_pkt(2'h0, 1'h1, 4'h2, 1'h1);
    rx_pkt(2'h2, 1'h0, 4'h0, 1'h0);
    rx_pkt(2'h1, 1'h0, 4'h0, 1'h0);
    wr(8'h74, 32'h0);
    rx_pkt(2'h0, 1'h0, 4'h2, 1'h0);
    complete_run();
  end
  initial begin
    repeat (20000) @(posedge clk_i);
    n_fail++;
    complete_run();
  end
endmodule
`default_nettype wire
